/* rtl/ctsc_top.sv */
// Capacitive touch scan controller with APB register access
//
// Behaviour
// [R1]: Pad select only enables pad touch function
// [R2]: Parallel scan drives timing on selected pads
// [R3]: Low select bit n enables channel n
// [R4]: Mid select low nibble maps channels 8-11
// [R5]: Groups c-f map channels 16-47
// [R6]: Resistor select in bits 5..3
// [R7]: Threshold select in bits 2..0
// [R8]: Power-down bit 1 disables touch block
// [R9]: Touch enable zero forces touch off
// [R10]: Software configures, starts, then reads result
// [R11]: Completion visible by polling or interrupt
// [R12]: Counter width is resolution plus nine
// [R13]: Count clock 24, 12, 6, 4 MHz; code divides the 50 MHz mclk by 1, 2, 4, 6
// [R14]: Software keeps count clock twice front-end
// [R15]: Divider codes 0-60 fixed, 61 slow
// [R16]: Codes 62, 63 give spread front-end clock
// [R17]: Pull current code is high bit, byte
// [R18]: Pull current resets to high one, low zero
// [R19]: Raw count is live counter value
// [R20]: Start rises begins, clears after, abort
// [R21]: Parallel bit picks parallel or single channel
// [R22]: Flag set on completion, written zero clears
// [R23]: Counter restarts, saturates at width maximum
`include "ctsc_params.svh"

module ctsc_top
  import ctsc_pkg::*;
(
  input  wire logic        mclk,          // System clock
  input  wire logic        reset,         // Synchronous reset
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB enable
  input  wire logic        pwrite,        // APB direction
  input  wire logic [11:0] paddr,         // APB byte address
  input  wire logic [31:0] pwdata,        // APB write data
  output logic      [31:0] prdata,        // APB read data
  output logic             pready,        // APB ready
  output logic             pslverr,       // APB error
  input  wire logic        senseActive,   // Comparator: keep counting
  input  wire logic        frontEndDone,  // Analog front end ends scan
  output logic      [47:0] padEnable,     // Touch function enable per pad
  output logic      [47:0] padDrive,      // Charge timing per pad
  output logic             analogOn,      // Analog touch block powered
  output logic      [2:0]  refResSel,     // Reference resistor code
  output logic      [2:0]  vthSel,        // Threshold voltage code
  output logic      [8:0]  pullCode,      // Pull-up current code
  output logic             touchIrqFlag   // Touch interrupt flag level
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Largest count for a resolution setting
  function automatic logic [15:0] countMax(input logic [2:0] count_resolution);
    logic [4:0] bits;
    bits = 5'(count_resolution) + 5'(`CTSC_RES_BASE_BITS);  // [R12]
    return 16'((32'h1 << bits) - 32'h1);
  endfunction : countMax

  // Count clock prescale, mclk ticks per count tick
  function automatic logic [2:0] countDiv(input logic [1:0] sel);
    unique case (sel)  // [R13]
      2'h0: return 3'h1;
      2'h1: return 3'h2;
      2'h2: return 3'h4;
      2'h3: return 3'h6;
    endcase
  endfunction : countDiv

  // Front-end half period in mclk ticks
  function automatic logic [5:0] halfPeriod(input logic [5:0] code,
                                            input logic [7:0] rnd);
    if (code <= 6'd60) begin
      return 6'(code >> 1) + 6'h04;  // [R15]
    end else if (code == 6'd61) begin
      return 6'(`CTSC_SLOW_HALF);  // [R15]
    end else begin
      // Sum of three small random terms bunches near the centre
      return 6'(`CTSC_SPREAD_MIN_HALF) + 6'(rnd[2:0]) + 6'(rnd[5:3])
             + 6'(rnd[7:6]);  // [R16]
    end
  endfunction : halfPeriod

  // Pad enable vector from the select bytes
  function automatic logic [47:0] padMap(input logic [5:0][7:0] sel);
    return {sel[5], sel[4], sel[3], sel[2], 4'h0, sel[1][3:0],
            sel[0]};  // [R3] [R4] [R5]
  endfunction : padMap

  // Single channel mask, empty for an unused address
  function automatic logic [47:0] chanMask(input logic [5:0] addr);
    if ((addr >= 6'd12 && addr <= 6'd15) || addr > 6'd47) begin
      return 48'h0;
    end
    return 48'h1 << addr;
  endfunction : chanMask

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ctsc_state_s_t r;            // Registered state
  ctsc_state_s_t n;            // Next state
  logic [7:0]    regIdx;       // Word index of the access
  logic          addrOk;       // Address inside the register window
  logic          wrEn;         // Write takes effect this edge
  logic          cntTick;      // Count clock tick
  logic          scanEnd;      // Scan completes this edge

  assign regIdx  = paddr[9:2];
  assign addrOk  = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign wrEn    = psel && penable && pwrite && r.pready;
  assign cntTick = (r.ctCnt == countDiv(r.cntSel) - 3'h1);
  assign scanEnd = (r.state == CTSC_SCAN) &&
                   (frontEndDone || r.rawCount == countMax(r.count_resolution));

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    n.lfsr    = {r.lfsr[6:0], r.lfsr[7] ^ r.lfsr[5] ^ r.lfsr[4] ^ r.lfsr[3]};

    // APB setup phase: prepare answer for the access phase
    if (psel && !penable) begin
      n.pready  = 1'b1;
      n.prdata  = 32'h0;
      n.pslverr = !addrOk;
      if (addrOk) begin
        unique case (regIdx)
          `CTSC_IDX_PAD_LOW:   n.prdata = 32'(r.padSel[0]);
          `CTSC_IDX_PAD_MID:   n.prdata = 32'(r.padSel[1]);
          `CTSC_IDX_PAD_C:     n.prdata = 32'(r.padSel[2]);
          `CTSC_IDX_PAD_D:     n.prdata = 32'(r.padSel[3]);
          `CTSC_IDX_PAD_E:     n.prdata = 32'(r.padSel[4]);
          `CTSC_IDX_PAD_F:     n.prdata = 32'(r.padSel[5]);
          `CTSC_IDX_ANA_CFG:   n.prdata = 32'(r.anaCfg);
          `CTSC_IDX_PWR_SW:    n.prdata = 32'(r.pwrSw);
          `CTSC_IDX_SCAN_CTRL: n.prdata = {18'h0, r.chanAddr, 5'h0, r.touchEn,
                                           r.parallel, r.state == CTSC_SCAN};
          `CTSC_IDX_SCAN_CFG:  n.prdata = {18'h0, r.cntSel, 1'b0, r.count_resolution,
                                           2'h0, r.feDiv};
          `CTSC_IDX_PULL_CUR:  n.prdata = {23'h0, r.pullHi, r.pullLo};  // [R17]
          `CTSC_IDX_RAW_COUNT: n.prdata = 32'(r.rawCount);  // [R19]
          `CTSC_IDX_STATUS:    n.prdata = {30'h0, r.state == CTSC_SCAN,
                                           r.irqFlag};  // [R11]
          default:             n.pslverr = 1'b1;  // Unmapped word
        endcase
      end
    end

    // Register writes at the completing access edge
    if (wrEn && addrOk) begin
      unique case (regIdx)
        `CTSC_IDX_PAD_LOW:   n.padSel[0] = pwdata[7:0];  // [R3]
        `CTSC_IDX_PAD_MID:   n.padSel[1] = pwdata[7:0] & `CTSC_MID_MASK;  // [R4]
        `CTSC_IDX_PAD_C:     n.padSel[2] = pwdata[7:0];  // [R5]
        `CTSC_IDX_PAD_D:     n.padSel[3] = pwdata[7:0];  // [R5]
        `CTSC_IDX_PAD_E:     n.padSel[4] = pwdata[7:0];  // [R5]
        `CTSC_IDX_PAD_F:     n.padSel[5] = pwdata[7:0];  // [R5]
        `CTSC_IDX_ANA_CFG:   n.anaCfg = pwdata[5:0];  // [R6] [R7]
        `CTSC_IDX_PWR_SW:    n.pwrSw = pwdata[7:0] & `CTSC_PWR_SW_MASK;  // [R8]
        `CTSC_IDX_SCAN_CTRL: begin
          n.parallel = pwdata[1];  // [R21]
          n.touchEn  = pwdata[2];
          n.chanAddr = pwdata[13:8];
          if (pwdata[0] && r.state == CTSC_IDLE) begin
            // Rising start bit: new scan from a cleared counter
            n.state    = CTSC_SCAN;  // [R20]
            n.rawCount = 16'h0;  // [R23]
            n.feCnt    = 6'h0;
            n.feClk    = 1'b0;
            n.ctCnt    = 3'h0;
          end else if (!pwdata[0] && r.state == CTSC_SCAN) begin
            // Start cleared mid-scan: stop at once, no flag unless the scan also completes at this edge
            n.state = CTSC_IDLE;  // [R20]
          end
        end
        `CTSC_IDX_SCAN_CFG: begin
          n.feDiv  = pwdata[5:0];
          n.count_resolution   = pwdata[10:8];  // [R12]
          n.cntSel = pwdata[13:12];  // [R13]
        end
        `CTSC_IDX_PULL_CUR: begin
          n.pullLo = pwdata[7:0];  // [R17]
          n.pullHi = pwdata[8];
        end
        `CTSC_IDX_STATUS: begin
          if (!pwdata[0]) begin
            n.irqFlag = 1'b0;  // [R22]
          end
        end
        default: ;  // Read-only or unmapped
      endcase
    end

    // Scan engine
    if (r.state == CTSC_SCAN && n.state == CTSC_SCAN) begin
      // Front-end charge clock
      if (r.feCnt >= halfPeriod(r.feDiv, r.lfsr) - 6'h1) begin
        n.feCnt = 6'h0;
        n.feClk = !r.feClk;
      end else begin
        n.feCnt = r.feCnt + 6'h1;
      end
      // Count clock prescaler
      n.ctCnt = cntTick ? 3'h0 : r.ctCnt + 3'h1;
      // Live counter, held at the width maximum
      if (cntTick && senseActive && r.rawCount != countMax(r.count_resolution)) begin
        n.rawCount = r.rawCount + 16'h1;  // [R23]
      end
    end
    // Completion wins over an abort written at the same edge
    if (scanEnd) begin
      n.state   = CTSC_IDLE;  // [R20]
      n.irqFlag = 1'b1;  // [R22]
    end
    // Narrower resolution pulls a held count back inside the width
    if (n.rawCount > countMax(n.count_resolution)) begin
      n.rawCount = countMax(n.count_resolution);  // [R23]
    end
    if (n.state == CTSC_IDLE) begin
      n.feClk = 1'b0;
    end

    // Pad side outputs
    n.padEnable = padMap(n.padSel);  // [R1]
    if (n.state == CTSC_SCAN && n.feClk) begin
      n.padDrive = n.parallel ? n.padEnable : chanMask(n.chanAddr);  // [R2] [R21]
    end else begin
      n.padDrive = 48'h0;
    end
    n.analogOn = n.touchEn && !n.pwrSw[`CTSC_PD_TOUCH_BIT];  // [R8] [R9]
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      r          <= '0;
      r.anaCfg   <= `CTSC_RST_ANA_CFG;
      r.pwrSw    <= `CTSC_RST_PWR_SW;
      r.count_resolution     <= `CTSC_RST_COUNT_RESOLUTION;
      r.pullHi   <= `CTSC_RST_PULL_HI;  // [R18]
      r.pullLo   <= `CTSC_RST_PULL_LO;  // [R18]
      r.lfsr     <= 8'h01;
      r.state    <= CTSC_IDLE;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata       = r.prdata;
  assign pready       = r.pready;
  assign pslverr      = r.pslverr;
  assign padEnable    = r.padEnable;
  assign padDrive     = r.padDrive;
  assign analogOn     = r.analogOn;
  assign refResSel    = r.anaCfg[5:3];  // [R6]
  assign vthSel       = r.anaCfg[2:0];  // [R7]
  assign pullCode     = {r.pullHi, r.pullLo};  // [R17]
  assign touchIrqFlag = r.irqFlag;  // [R11]

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Write strobe to a given word
  sequence s_wr(logic [7:0] idx);
    wrEn && addrOk && regIdx == idx;
  endsequence

  // Scan starts from idle
  sequence s_start;
    s_wr(`CTSC_IDX_SCAN_CTRL) ##0 pwdata[0] && r.state == CTSC_IDLE;
  endsequence

  property p_low_map;  // [R3]
    logic [7:0] d;
    (s_wr(`CTSC_IDX_PAD_LOW), d = pwdata[7:0]) |=> padEnable[7:0] == d;
  endproperty
  a_low_map: assert property (p_low_map) else $error("low pad map wrong");  // [R3]

  property p_mid_map;  // [R4]
    logic [3:0] d;
    (s_wr(`CTSC_IDX_PAD_MID), d = pwdata[3:0]) |=> padEnable[15:8] == {4'h0, d};
  endproperty
  a_mid_map: assert property (p_mid_map) else $error("mid pad map wrong");  // [R4]

  property p_group_f_map;  // [R5]
    logic [7:0] d;
    (s_wr(`CTSC_IDX_PAD_F), d = pwdata[7:0]) |=> padEnable[47:40] == d;
  endproperty
  a_group_f_map: assert property (p_group_f_map) else $error("group f map wrong");  // [R5]

  property p_parallel_drive;  // [R2]
    r.state == CTSC_SCAN && r.parallel |-> padDrive == (r.feClk ? padEnable : 48'h0);
  endproperty
  a_parallel_drive: assert property (p_parallel_drive) else $error("parallel drive");  // [R2]

  property p_single_drive;  // [R21]
    !r.parallel |-> (padDrive & ~chanMask(r.chanAddr)) == 48'h0;
  endproperty
  a_single_drive: assert property (p_single_drive) else $error("single drive leak");  // [R21]

  property p_touch_gate;  // [R9]
    analogOn == (r.touchEn && !r.pwrSw[`CTSC_PD_TOUCH_BIT]);
  endproperty
  a_touch_gate: assert property (p_touch_gate) else $error("touch power gate");  // [R9]

  property p_start_clears;  // [R20] [R23]
    s_start |=> r.state == CTSC_SCAN && r.rawCount == 16'h0;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("start failed");  // [R20]

  property p_abort;  // [R20]
    s_wr(`CTSC_IDX_SCAN_CTRL) ##0 !pwdata[0] |=> r.state == CTSC_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("abort failed");  // [R20]

  property p_done_flag;  // [R22]
    scanEnd |=> r.irqFlag && r.state == CTSC_IDLE;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("flag not set");  // [R22]

  property p_count_cap;  // [R23]
    r.rawCount <= countMax(r.count_resolution);
  endproperty
  a_count_cap: assert property (p_count_cap) else $error("count over width");  // [R23]

  property p_pull_reset;  // [R18]
    $past(reset) |-> pullCode == 9'h100;
  endproperty
  a_pull_reset: assert property (p_pull_reset) else $error("pull reset value");  // [R18]

endmodule : ctsc_top

/* rtl/ctsc_params.svh */
// Offsets, reset values and timing counts of the touch scan controller
`ifndef CTSC_PARAMS_SVH
`define CTSC_PARAMS_SVH

// ------------------------------------------------------------------
// Register indices (byte address = index * 4)
// ------------------------------------------------------------------
`define CTSC_IDX_PAD_LOW      8'h26
`define CTSC_IDX_PAD_MID      8'h27
`define CTSC_IDX_PAD_C        8'h28
`define CTSC_IDX_PAD_D        8'h29
`define CTSC_IDX_ANA_CFG      8'h2b
`define CTSC_IDX_PWR_SW       8'h2d
`define CTSC_IDX_PAD_E        8'h51
`define CTSC_IDX_PAD_F        8'h52
`define CTSC_IDX_SCAN_CTRL    8'h60
`define CTSC_IDX_SCAN_CFG     8'h61
`define CTSC_IDX_PULL_CUR     8'h62
`define CTSC_IDX_RAW_COUNT    8'h63
`define CTSC_IDX_STATUS       8'h64

// ------------------------------------------------------------------
// Reset values and field positions
// ------------------------------------------------------------------
`define CTSC_RST_ANA_CFG      6'h2f
`define CTSC_RST_PWR_SW       8'h53
`define CTSC_PWR_SW_MASK      8'h53
`define CTSC_RST_COUNT_RESOLUTION         3'h7
`define CTSC_RST_PULL_HI      1'h1
`define CTSC_RST_PULL_LO      8'h00
`define CTSC_PD_TOUCH_BIT     1
`define CTSC_MID_MASK         8'h0f

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define CTSC_CLK_HZ           50000000
`define CTSC_SLOW_FE_HZ       400000
`define CTSC_SLOW_HALF        (`CTSC_CLK_HZ / (2 * `CTSC_SLOW_FE_HZ))
`define CTSC_SPREAD_MIN_HALF  8
`define CTSC_RES_BASE_BITS    9

`endif

/* rtl/ctsc_pkg.sv */
// Types of the touch scan controller
package ctsc_pkg;

  // ----------------------------------------------------------------
  // Scan sequencer states
  // ----------------------------------------------------------------
  typedef enum logic {
    CTSC_IDLE,
    CTSC_SCAN
  } ctsc_state_t;

  // ----------------------------------------------------------------
  // Whole module state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0][7:0] padSel;       // Pad select bytes, low to group f
    logic [5:0]      anaCfg;       // Resistor and threshold selects
    logic [7:0]      pwrSw;        // Analog power switches
    logic            touchEn;      // Touch enable
    logic            parallel;     // Parallel scanning
    logic [5:0]      chanAddr;     // Addressed channel
    logic [5:0]      feDiv;        // Front-end divider code
    logic [2:0]      count_resolution;         // Count resolution
    logic [1:0]      cntSel;       // Count clock select
    logic [7:0]      pullLo;       // Pull current low byte
    logic            pullHi;       // Pull current high bit
    logic [15:0]     rawCount;     // Capacitance counter
    logic            irqFlag;      // Touch interrupt flag
    ctsc_state_t     state;        // Scan sequencer
    logic [5:0]      feCnt;        // Front-end half period counter
    logic            feClk;        // Front-end clock level
    logic [2:0]      ctCnt;        // Count clock prescaler
    logic [7:0]      lfsr;         // Spread spectrum source
    logic            pready;       // APB ready
    logic [31:0]     prdata;       // APB read data
    logic            pslverr;      // APB error
    logic [47:0]     padEnable;    // Pad sense function enables
    logic [47:0]     padDrive;     // Pad scan timing
    logic            analogOn;     // Analog touch block on
  } ctsc_state_s_t;

endpackage : ctsc_pkg

/* bench/ctsc_pad_model.sv */
// Sense pad and analog front-end model facing the touch scan controller
module ctsc_pad_model (
  input  wire logic        mclk,          // System clock
  input  wire logic        reset,         // Synchronous reset
  input  wire logic [47:0] padDrive,      // Scan timing from the block
  input  wire logic        analogOn,      // Analog touch block powered
  input  wire logic [7:0]  doneEdges,     // Drive edges to finish, zero never
  output logic             senseActive,   // Comparator keeps counting
  output logic             frontEndDone   // End of conversion pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       drvLast_ff;                 // Previous drive activity
  logic [7:0] edgeCnt_ff;                 // Rising drive edges seen
  // ------------------------------------------------------------
  // Comparator and completion
  // ------------------------------------------------------------
  // Only a powered analog block lets the counter run
  assign senseActive = analogOn;
  // Finish after a set number of charge cycles, promptly or slowly
  always_ff @(posedge mclk) begin
    drvLast_ff   <= |padDrive;
    frontEndDone <= 1'b0;
    if (reset || doneEdges == 8'h00) begin
      edgeCnt_ff <= 8'h00;
    end else if (|padDrive && !drvLast_ff) begin
      if (edgeCnt_ff + 8'h01 == doneEdges) begin
        frontEndDone <= 1'b1;
        edgeCnt_ff   <= 8'h00;
      end else begin
        edgeCnt_ff <= edgeCnt_ff + 8'h01;
      end
    end
  end
endmodule : ctsc_pad_model

/* bench/tb.sv */
// Self-checking bench of the touch scan controller
`include "ctsc_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, reset, psel, penable, pwrite, pready, pslverr;  // Clock, reset, APB
  logic [11:0] paddr;                                              // APB byte address
  logic [31:0] pwdata, prdata;                                     // APB data
  logic        senseActive, frontEndDone, analogOn, touchIrqFlag;  // Scan status
  logic [47:0] padEnable, padDrive, expEn, got, bad;               // Pad outputs
  logic [2:0]  refResSel, vthSel;                                  // Analog selects
  logic [8:0]  pullCode;                                           // Pull current code
  logic [7:0]  doneEdges;                                          // Model finish count
  logic [31:0] d1, d2;                                             // Read scratch
  logic        e;                                                  // Error scratch
  int          miscompares, check_count, cycles, n, t, ex;         // Bookkeeping
  logic [7:0]  padIdx [6] = '{`CTSC_IDX_PAD_LOW, `CTSC_IDX_PAD_MID, `CTSC_IDX_PAD_C,
                              `CTSC_IDX_PAD_D, `CTSC_IDX_PAD_E, `CTSC_IDX_PAD_F};
  int          padBase [6] = '{0, 8, 16, 24, 32, 40};              // First channel per reg
  int          divCode [6] = '{0, 5, 60, 61, 62, 63};              // Divider codes tried
  int          halfLo [6]  = '{4, 6, 34, 62, 8, 8};                // Shortest half period
  int          halfHi [6]  = '{4, 6, 34, 62, 25, 25};              // Longest half period
  int          tick [5]    = '{1, 2, 4, 6, 1};                     // Cycles per count tick
  int          resoTab [5] = '{0, 0, 0, 0, 1};                     // Resolution per case
  // ------------------------------------------------------------
  // Design and pad model
  // ------------------------------------------------------------
  ctsc_top u_dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .senseActive(senseActive), .frontEndDone(frontEndDone),
    .padEnable(padEnable), .padDrive(padDrive), .analogOn(analogOn),
    .refResSel(refResSel), .vthSel(vthSel), .pullCode(pullCode),
    .touchIrqFlag(touchIrqFlag));
  ctsc_pad_model u_pad (.mclk(mclk), .reset(reset), .padDrive(padDrive),
    .analogOn(analogOn), .doneEdges(doneEdges), .senseActive(senseActive),
    .frontEndDone(frontEndDone));
  // ------------------------------------------------------------
  // Clock and hang guard
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, idx, wd, rd, err);
    repeat (2) @(negedge mclk);
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, idx, 32'h0, rd, err);
    check($sformatf("register %h", idx), rd, exp);
  endtask : rdc
  // Cycles between two changes of the channel 0 drive
  task automatic half(output int cnt);
    logic lvl;
    cnt = 0;
    @(negedge mclk);
    lvl = padDrive[0];
    while (padDrive[0] === lvl && cnt < 200) begin
      @(negedge mclk);
      cnt++;
    end
    lvl = padDrive[0];
    cnt = 0;
    while (padDrive[0] === lvl && cnt < 200) begin
      @(negedge mclk);
      cnt++;
    end
  endtask : half
  // Watch drives until the flag rises
  task automatic watch();
    got = '0;
    bad = '0;
    t = 0;
    while (touchIrqFlag !== 1'b1 && t < 5000) begin
      @(negedge mclk);
      got = got | padDrive;
      bad = bad | (padDrive & ~expEn);
      t++;
    end
  endtask : watch
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    doneEdges = 8'h00;
    miscompares = 0;
    check_count = 0;
    cycles = 0;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    // Reset values
    for (int i = 0; i < 6; i++) rdc(padIdx[i], 32'h0);
    rdc(`CTSC_IDX_ANA_CFG, 32'h2f);
    rdc(`CTSC_IDX_PWR_SW, 32'h53);
    rdc(`CTSC_IDX_PULL_CUR, 32'h100);
    check("pullCode", pullCode, 9'h100);
    rdc(`CTSC_IDX_SCAN_CFG, 32'h700);
    check("analogOn", analogOn, 1'b0);
    // Pad select map, one bit at a time
    for (int i = 0; i < 6; i++) begin
      for (int b = 0; b < 8; b++) begin
        wr(padIdx[i], 32'h1 << b);
        expEn = (i == 1 && b > 3) ? 48'h0 : 48'h1 << (padBase[i] + b);
        check("padEnable", padEnable, expEn);
        rdc(padIdx[i], (i == 1 && b > 3) ? 32'h0 : 32'h1 << b);
      end
      wr(padIdx[i], 32'h0);
    end
    // Resistor and threshold codes, reserved resistor codes kept out
    for (int c = 0; c < 8; c++) begin
      wr(`CTSC_IDX_ANA_CFG, ((2 + c % 2) << 3) | (7 - c));
      check("refResSel", refResSel, 2 + c % 2);
      check("vthSel", vthSel, 7 - c);
    end
    wr(`CTSC_IDX_ANA_CFG, 32'h13);
    // Power switches and touch enable
    wr(`CTSC_IDX_PWR_SW, 32'hff);
    rdc(`CTSC_IDX_PWR_SW, 32'h53);
    wr(`CTSC_IDX_PWR_SW, 32'h00);
    wr(`CTSC_IDX_SCAN_CTRL, 32'h0);
    check("analogOn", analogOn, 1'b0);
    wr(`CTSC_IDX_SCAN_CTRL, 32'h4);
    check("analogOn", analogOn, 1'b1);
    wr(`CTSC_IDX_PWR_SW, 32'h02);
    check("analogOn", analogOn, 1'b0);
    wr(`CTSC_IDX_PWR_SW, 32'h00);
    // Pull current code
    wr(`CTSC_IDX_PULL_CUR, 32'h0ab);
    check("pullCode", pullCode, 9'h0ab);
    wr(`CTSC_IDX_PULL_CUR, 32'h1c5);
    rdc(`CTSC_IDX_PULL_CUR, 32'h1c5);
    check("pullCode", pullCode, 9'h1c5);
    // Unmapped address is refused
    apb(1'b0, 8'h30, 32'h0, d1, e);
    check("unmapped error", e, 1'b1);
    check("unmapped data", d1, 32'h0);
    // Counter saturation and count clock rate, then flag handling
    for (int k = 0; k < 5; k++) begin
      wr(`CTSC_IDX_SCAN_CFG, (k % 4 << 12) | (resoTab[k] << 8) | 8);
      wr(`CTSC_IDX_SCAN_CTRL, 32'h5);
      t = 0;
      while (touchIrqFlag !== 1'b1 && t < 5000) begin
        @(negedge mclk);
        t++;
      end
      ex = ((1 << (9 + resoTab[k])) - 1) * tick[k];
      check("scan length", (t >= ex - 12) && (t <= ex + 12), 1'b1);
      rdc(`CTSC_IDX_RAW_COUNT, (1 << (9 + resoTab[k])) - 1);
      rdc(`CTSC_IDX_STATUS, 32'h1);
      rdc(`CTSC_IDX_SCAN_CTRL, 32'h4);
      wr(`CTSC_IDX_STATUS, 32'h1);
      check("flag kept", touchIrqFlag, 1'b1);
      wr(`CTSC_IDX_STATUS, 32'h0);
      check("flag cleared", touchIrqFlag, 1'b0);
    end
    // Parallel scan drives every selected pad, single scan the addressed one
    wr(`CTSC_IDX_PAD_LOW, 32'h01);
    wr(`CTSC_IDX_PAD_C, 32'h01);
    wr(`CTSC_IDX_PAD_F, 32'h80);
    wr(`CTSC_IDX_SCAN_CFG, 32'h700);
    for (int m = 0; m < 2; m++) begin
      expEn = m == 0 ? 48'h8000_0001_0001 : 48'h20;
      doneEdges = 8'h03 - m;
      wr(`CTSC_IDX_SCAN_CTRL, m == 0 ? 32'h7 : 32'h505);
      watch();
      check("pads driven", got, expEn);
      check("stray drive", bad, 48'h0);
      check("drive after scan", padDrive, 48'h0);
      rdc(`CTSC_IDX_STATUS, 32'h1);
      wr(`CTSC_IDX_STATUS, 32'h0);
    end
    // Front-end half periods, live count and abort
    doneEdges = 8'h00;
    for (int j = 0; j < 6; j++) begin
      wr(`CTSC_IDX_SCAN_CFG, 32'h700 | divCode[j]);
      wr(`CTSC_IDX_SCAN_CTRL, 32'h5);
      half(n);
      check("half period", (n >= halfLo[j]) && (n <= halfHi[j]), 1'b1);
      apb(1'b0, `CTSC_IDX_RAW_COUNT, 32'h0, d1, e);
      apb(1'b0, `CTSC_IDX_RAW_COUNT, 32'h0, d2, e);
      check("raw count live", d2 > d1, 1'b1);
      wr(`CTSC_IDX_SCAN_CTRL, 32'h4);
      rdc(`CTSC_IDX_STATUS, 32'h0);
      check("drive after abort", padDrive, 48'h0);
    end
    tally_and_finish();
  end
endmodule : tb
